// *** design/tcmc_defines.vh ***
// Purpose: Shared constants for the transmit character and mode control block
// Assumes: Three-level selects arrive as two-bit level codes per pin
// Notes:   Definitions only; included by bare name
`ifndef TCMC_DEFINES_VH
`define TCMC_DEFINES_VH

// Decoded three-level pin states (pin code 2'b11 decodes as high)
`define TCMC_LVL_L      2'h0
`define TCMC_LVL_M      2'h1
`define TCMC_LVL_H      2'h2

// Character kinds handed to the shifter side
`define TCMC_K_BYPASS   3'h0
`define TCMC_K_DATA     3'h1
`define TCMC_K_SPECIAL  3'h2
`define TCMC_K_FILL     3'h3
`define TCMC_K_SYNC     3'h4

// Control bit patterns
`define TCMC_CTL_DATA   2'h0
`define TCMC_CTL_FILL   2'h1
`define TCMC_CTL_SPEC   2'h2
`define TCMC_CTL_SYNC   2'h3

// Fields of the synchronised configuration word
`define TCMC_CFG_OP_LO  1:0
`define TCMC_CFG_OP_HI  3:2
`define TCMC_CFG_BOND   7:6
`define TCMC_CFG_CKSEL  9:8
`define TCMC_CFG_TBL    10

// Word sync sequence positions: first, second and last of 16
`define TCMC_SEQ_FIRST  4'h0
`define TCMC_SEQ_SECOND 4'h1
`define TCMC_SEQ_LAST   4'hf

// Geometry
`define TCMC_CHANS      4
`define TCMC_CHAR_W     8
`define TCMC_CODE_W     10
`define TCMC_KIND_W     3
`define TCMC_CNT_W      4

`endif

// *** design/tcmc_char_buf.v ***
// Purpose: Small FIFO between character selection and the shifter side
// Assumes: Single clock, synchronous active-high reset
// Notes:   Storage is flip-flops; full and empty come from a held count
`timescale 1ns/1ps
`default_nettype none

module tcmc_char_buf #(
    parameter WIDTH = 52,
    parameter DEPTH = 2,
    parameter AW    = 1
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    wire            push;
    wire            pop;

    // Handshakes come from the held count, so a full buffer refuses even in a cycle that pops
    assign in_ready  = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointer wrap works for any depth, not only powers of two
    always @(posedge clk) begin
        if (rst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem_reg[wr_ptr_reg] <= in_data;
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
            end
            if (push & ~pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop & ~push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule // tcmc_char_buf

`default_nettype wire

// *** design/tcmc_tx_char_ctrl.v ***
// Purpose: Transmit character selection and mode control for four channels
// Assumes: Pins and pin clocks are asynchronous to clk and pass two flops;
//          the 8b/10b code tables sit downstream and read kind plus payload
// Notes:   One word per captured character; a full buffer drops the capture
//          and shows it by tx_char_ready low
//
// Summary of operation
// - Mode 0 passes ten captured bits unchanged
// - Bypass bit order a..j, a sent first
// - Bypass ignores table select, channels unlinked
// - Test modes emit fill, never lock up
// - Upper level mid atomic, high interruptible unless bonded
// - Modes 3,6: data, fill, word sync
// - Modes 4,7: data, fill, special code
// - Modes 5,8 unbonded: data, fill, special, sync
// - Atomic sequence runs 16, ignores inputs
// - Start sampled at end restarts sequence
// - Interruptible starts at once, continues on 00
// - Non-00 ends sequence, encodes presented character
// - Clock select picks reference or channel A clock
// - Dual bonding pairs A with B, C with D
// - Bonded pairs share bit 0, own bit 1
// - Channel B bit 0 starts A,B sync
// - Channel D bit 0 starts C,D sync
// - Quad bonding: A,B bit 0 rule all
// - Encoded modes tag characters for 8b/10b encoding
`timescale 1ns/1ps
`include "tcmc_defines.vh"
`default_nettype none

module tcmc_tx_char_ctrl #(
    parameter NCH    = `TCMC_CHANS,
    parameter BUF_DP = 2,
    parameter BUF_AW = 1
) (
    input  wire                                   clk,
    input  wire                                   rst,
    input  wire [3:0]                             tx_op_sel,
    input  wire [3:0]                             rx_bonding_sel,
    input  wire [1:0]                             tx_input_clk_sel,
    input  wire                                   special_code_table_sel,
    input  wire                                   reference_clock,
    input  wire                                   chan_a_input_clock,
    input  wire [NCH*`TCMC_CHAR_W-1:0]            tx_char_in,
    input  wire [NCH*2-1:0]                       tx_char_ctl,
    output wire                                   tx_char_ready,
    output wire                                   tx_code_valid,
    input  wire                                   tx_code_ready,
    output wire [NCH*`TCMC_KIND_W-1:0]            tx_code_kind,
    output wire [NCH*`TCMC_CODE_W-1:0]            tx_code_data,
    output reg  [3:0]                             tx_mode_num_reg,
    output reg  [NCH-1:0]                         seq_on_reg
);
    localparam CW = `TCMC_CHAR_W;
    localparam OW = `TCMC_CODE_W;
    localparam KW = `TCMC_KIND_W;
    localparam NW = `TCMC_CNT_W;
    localparam BW = NCH * (KW + OW);

    // Map a pin code onto a decoded level
    function [1:0] tcmc_lvl;
        input [1:0] pin;
        begin
            if (pin[1]) begin
                tcmc_lvl = `TCMC_LVL_H;
            end else if (pin[0]) begin
                tcmc_lvl = `TCMC_LVL_M;
            end else begin
                tcmc_lvl = `TCMC_LVL_L;
            end
        end
    endfunction

    // Kind requested by a control pattern in an encoded mode, by lower level
    function [KW-1:0] tcmc_kind;
        input [1:0] lo;
        input [1:0] c;
        begin
            if (lo == `TCMC_LVL_H) begin
                case (c)
                    `TCMC_CTL_DATA: tcmc_kind = `TCMC_K_DATA;
                    `TCMC_CTL_FILL: tcmc_kind = `TCMC_K_FILL;
                    `TCMC_CTL_SPEC: tcmc_kind = `TCMC_K_SPECIAL;
                    default:        tcmc_kind = `TCMC_K_SYNC;
                endcase
            end else if (!c[0]) begin
                tcmc_kind = `TCMC_K_DATA;
            end else if (!c[1]) begin
                tcmc_kind = `TCMC_K_FILL;
            end else if (lo == `TCMC_LVL_M) begin
                tcmc_kind = `TCMC_K_SPECIAL;
            end else begin
                tcmc_kind = `TCMC_K_SYNC;
            end
        end
    endfunction

    // Synchroniser stages: first flops feed only the second ones
    reg [10:0]           cfg_s1_reg;
    reg [10:0]           cfg_s2_reg;
    reg [1:0]            clk_s1_reg;
    reg [1:0]            clk_s2_reg;
    reg [1:0]            clk_s3_reg;
    reg [NCH*(CW+2)-1:0] dat_s1_reg;
    reg [NCH*(CW+2)-1:0] dat_s2_reg;

    reg [NCH-1:0]        seq_atom_reg;
    reg [NCH*NW-1:0]     seq_cnt_reg;
    reg [NCH-1:0]        seq_on_next;
    reg [NCH-1:0]        seq_atom_next;
    reg [NCH*NW-1:0]     seq_cnt_next;
    reg [NCH*KW-1:0]     kind_next;
    reg [NCH*OW-1:0]     code_next;

    wire [1:0]           op_hi;
    wire [1:0]           op_lo;
    wire [1:0]           bond_hi;
    wire [1:0]           cksel;
    wire                 tbl_sel;
    wire [NCH*CW-1:0]    chr;
    wire [NCH*2-1:0]     ctl;
    wire                 ref_rise;
    wire                 cha_rise;
    wire                 cap_edge;
    wire                 buf_in_ready;
    wire                 strobe;
    wire                 bonded;
    wire [BW-1:0]        buf_out;

    // Configuration, pin clocks and character pins all pass two flops
    always @(posedge clk) begin
        if (rst) begin
            cfg_s1_reg <= 11'h000;
            cfg_s2_reg <= 11'h000;
            clk_s1_reg <= 2'h0;
            clk_s2_reg <= 2'h0;
            clk_s3_reg <= 2'h0;
            dat_s1_reg <= {NCH*(CW+2){1'b0}};
            dat_s2_reg <= {NCH*(CW+2){1'b0}};
        end else begin
            cfg_s1_reg <= {special_code_table_sel, tx_input_clk_sel, rx_bonding_sel, tx_op_sel};
            cfg_s2_reg <= cfg_s1_reg;
            clk_s1_reg <= {chan_a_input_clock, reference_clock};
            clk_s2_reg <= clk_s1_reg;
            clk_s3_reg <= clk_s2_reg;
            dat_s1_reg <= {tx_char_ctl, tx_char_in};
            dat_s2_reg <= dat_s1_reg;
        end
    end

    // Selects are static in use; no glitch filtering is attempted
    assign op_lo   = tcmc_lvl(cfg_s2_reg[`TCMC_CFG_OP_LO]);
    assign op_hi   = tcmc_lvl(cfg_s2_reg[`TCMC_CFG_OP_HI]);
    assign bond_hi = tcmc_lvl(cfg_s2_reg[`TCMC_CFG_BOND]);
    assign cksel   = tcmc_lvl(cfg_s2_reg[`TCMC_CFG_CKSEL]);
    assign tbl_sel = cfg_s2_reg[`TCMC_CFG_TBL];
    assign chr     = dat_s2_reg[NCH*CW-1:0];
    assign ctl     = dat_s2_reg[NCH*(CW+2)-1:NCH*CW];

    // Character clock: rising edge of the selected pin clock
    assign ref_rise = clk_s2_reg[0] & ~clk_s3_reg[0];
    assign cha_rise = clk_s2_reg[1] & ~clk_s3_reg[1];
    assign cap_edge = (cksel == `TCMC_LVL_H) ? cha_rise : ref_rise;

    // A full buffer stalls capture; the sequencers wait with it
    assign strobe        = cap_edge & buf_in_ready;
    assign tx_char_ready = buf_in_ready;

    // Bonding only reshapes the combined-table modes 5 and 8
    assign bonded = (op_lo == `TCMC_LVL_H) && (bond_hi != `TCMC_LVL_L);

    // Per-channel character choice and word sync sequencing
    integer ch;
    integer ld;
    integer fw;
    reg [1:0]    c;
    reg [CW-1:0] d;
    reg [KW-1:0] rq;
    reg [NW-1:0] n;
    reg          grp_start;
    always @* begin
        seq_on_next   = seq_on_reg;
        seq_atom_next = seq_atom_reg;
        seq_cnt_next  = seq_cnt_reg;
        kind_next     = {NCH*KW{1'b0}};
        code_next     = {NCH*OW{1'b0}};
        c  = 2'h0;
        d  = {CW{1'b0}};
        rq = `TCMC_K_DATA;
        n  = `TCMC_SEQ_FIRST;
        grp_start = 1'b0;
        ld = 0;
        fw = 0;
        for (ch = 0; ch < NCH; ch = ch + 1) begin
            c = ctl[ch*2 +: 2];
            d = chr[ch*CW +: CW];
            n = seq_cnt_reg[ch*NW +: NW];
            // Group lead and follower for bonded operation
            if (bond_hi == `TCMC_LVL_H) begin
                ld = 0;
            end else begin
                ld = (ch / 2) * 2;
            end
            fw = ld + 1;
            if (op_hi == `TCMC_LVL_L) begin
                seq_on_next[ch] = 1'b0;
                if (op_lo == `TCMC_LVL_L) begin
                    // Raw ten bits, a..j from bit 0 upward; no table select
                    kind_next[ch*KW +: KW] = `TCMC_K_BYPASS;
                    code_next[ch*OW +: OW] = {c, d};
                end else begin
                    // Test codes: harmless idle fill, sequencers parked
                    kind_next[ch*KW +: KW] = `TCMC_K_FILL;
                end
            end else if (seq_on_reg[ch] && (seq_atom_reg[ch] || c == `TCMC_CTL_DATA)) begin
                // Running sequence; atomic ones ignore the input register
                kind_next[ch*KW +: KW] = `TCMC_K_SYNC;
                code_next[ch*OW +: OW] = {{(OW-NW){1'b0}}, n};
                seq_cnt_next[ch*NW +: NW] = n + 1'b1;
                if (n == `TCMC_SEQ_LAST) begin
                    seq_on_next[ch] = 1'b0;
                end
            end else begin
                // Idle, or an interruptible run cut short by non-00
                seq_on_next[ch] = 1'b0;
                if (bonded) begin
                    // Follower bit 0, or lead 11, starts the whole group
                    grp_start = ctl[fw*2] | (ctl[ld*2] & ctl[ld*2+1]);
                    rq = tcmc_kind(`TCMC_LVL_H, {c[1], ctl[ld*2]});
                    if (grp_start) begin
                        rq = `TCMC_K_SYNC;
                    end else if (rq == `TCMC_K_SYNC) begin
                        rq = `TCMC_K_FILL;
                    end
                end else begin
                    rq = tcmc_kind(op_lo, c);
                end
                kind_next[ch*KW +: KW] = rq;
                case (rq)
                    `TCMC_K_DATA: begin
                        code_next[ch*OW +: OW] = {2'h0, d};
                    end
                    `TCMC_K_SPECIAL: begin
                        code_next[ch*OW +: OW] = {tbl_sel, 1'b0, d};
                    end
                    `TCMC_K_SYNC: begin
                        // First character goes out now; bonded runs are atomic
                        seq_on_next[ch] = 1'b1;
                        seq_atom_next[ch] = (op_hi == `TCMC_LVL_M) | bonded;
                        seq_cnt_next[ch*NW +: NW] = `TCMC_SEQ_SECOND;
                        code_next[ch*OW +: OW] = {{(OW-NW){1'b0}}, `TCMC_SEQ_FIRST};
                    end
                    default: begin
                        code_next[ch*OW +: OW] = {OW{1'b0}};
                    end
                endcase
            end
        end
    end

    // Sequencer state moves only on an accepted character clock
    always @(posedge clk) begin
        if (rst) begin
            seq_on_reg      <= {NCH{1'b0}};
            seq_atom_reg    <= {NCH{1'b0}};
            seq_cnt_reg     <= {NCH*NW{1'b0}};
            tx_mode_num_reg <= 4'h0;
        end else begin
            tx_mode_num_reg <= {op_hi, 2'h0} - {2'h0, op_hi} + {2'h0, op_lo} + {op_hi, 2'h0} - {op_hi, 2'h0};
            if (strobe) begin
                seq_on_reg   <= seq_on_next;
                seq_atom_reg <= seq_atom_next;
                seq_cnt_reg  <= seq_cnt_next;
            end
        end
    end

    // Two-entry buffer holds two words for a stalled shifter side; later captures drop
    tcmc_char_buf #(
        .WIDTH (BW),
        .DEPTH (BUF_DP),
        .AW    (BUF_AW)
    ) u_buf (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (cap_edge),
        .in_ready  (buf_in_ready),
        .in_data   ({kind_next, code_next}),
        .out_valid (tx_code_valid),
        .out_ready (tx_code_ready),
        .out_data  (buf_out)
    );

    assign tx_code_kind = buf_out[BW-1:NCH*OW];
    assign tx_code_data = buf_out[NCH*OW-1:0];
endmodule // tcmc_tx_char_ctrl

`default_nettype wire

// *** bench/tcmc_ctrl_properties.sv ***
// Purpose: Port checks for the transmit character and mode control block
// Assumes: Selects change only while the output buffer is empty
// Notes:   Mode checks wait until the selects have been steady 8 clocks
`timescale 1ns/1ps
`include "tcmc_defines.vh"
`default_nettype none
module tcmc_ctrl_properties (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [3:0]  tx_op_sel,
    input wire logic [3:0]  rx_bonding_sel,
    input wire logic        tx_char_ready,
    input wire logic        tx_code_valid,
    input wire logic        tx_code_ready,
    input wire logic [11:0] tx_code_kind,
    input wire logic [39:0] tx_code_data,
    input wire logic [3:0]  tx_mode_num_reg,
    input wire logic [3:0]  seq_on_reg
);
    logic [5:0]      cfg_q;
    logic [3:0]      age;
    wire logic [5:0] cfg = {tx_op_sel, rx_bonding_sel[3:2]};
    wire logic [1:0] up  = tx_op_sel[3] ? 2'h2 : {1'b0, tx_op_sel[2]};
    wire logic [1:0] lo  = tx_op_sel[1] ? 2'h2 : {1'b0, tx_op_sel[0]};
    wire logic       ok  = age[3] && (cfg_q == cfg);
    wire logic       vw  = ok && tx_code_valid;
    // Select age; words just after a change may still carry the old mode
    always_ff @(posedge clk) begin
        cfg_q <= cfg;
        if (rst || cfg_q != cfg) begin
            age <= 4'h0;
        end else if (!age[3]) begin
            age <= age + 4'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_MODE_NUM: assert property (ok |-> tx_mode_num_reg == 4'(up) * 4'h3 + 4'(lo))
        else $error("mode number wrong");
    AST_BYPASS: assert property (vw && up == 2'h0 && lo == 2'h0 |-> tx_code_kind == 12'h0)
        else $error("bypass kind wrong");
    AST_TEST_FILL: assert property (vw && up == 2'h0 && lo != 2'h0 |-> tx_code_kind == 12'h6db && tx_code_data == 40'h0)
        else $error("test mode word wrong");
    AST_TEST_NOSEQ: assert property (ok && up == 2'h0 |-> seq_on_reg == 4'h0)
        else $error("sequence on in unencoded mode");
    AST_ENCODED: assert property (vw && up != 2'h0 |-> tx_code_kind[2:0] != 3'h0 && tx_code_kind[11:9] != 3'h0)
        else $error("bypass kind in encoded mode");
    AST_NO_SPEC36: assert property (vw && up != 2'h0 && lo == 2'h0
        |-> tx_code_kind[2:0] != `TCMC_K_SPECIAL
        && tx_code_kind[5:3] != `TCMC_K_SPECIAL && tx_code_kind[8:6] != `TCMC_K_SPECIAL)
        else $error("special code in mode 3 or 6");
    AST_FILL_ZERO: assert property (tx_code_valid && tx_code_kind[2:0] == `TCMC_K_FILL |-> tx_code_data[9:0] == 10'h0)
        else $error("fill payload not zero");
    AST_SYNC_POS: assert property (tx_code_valid && tx_code_kind[2:0] == `TCMC_K_SYNC |-> tx_code_data[9:4] == 6'h0)
        else $error("sync position out of range");
    AST_PAIR_SYNC: assert property (vw && cfg[1:0] != 2'h0 && lo == 2'h2
        && tx_code_kind[2:0] == `TCMC_K_SYNC |-> tx_code_kind[5:3] == `TCMC_K_SYNC)
        else $error("bonded pair not in sync together");
    AST_HOLD: assert property (tx_code_valid && !tx_code_ready |=> tx_code_valid && $stable(tx_code_data))
        else $error("stalled word changed");
    AST_ROOM: assert property (!tx_code_valid |-> tx_char_ready)
        else $error("empty buffer refuses");
endmodule // tcmc_ctrl_properties
bind tcmc_tx_char_ctrl tcmc_ctrl_properties chk_u (
    .clk(clk), .rst(rst), .tx_op_sel(tx_op_sel), .rx_bonding_sel(rx_bonding_sel),
    .tx_char_ready(tx_char_ready), .tx_code_valid(tx_code_valid), .tx_code_ready(tx_code_ready),
    .tx_code_kind(tx_code_kind), .tx_code_data(tx_code_data), .tx_mode_num_reg(tx_mode_num_reg),
    .seq_on_reg(seq_on_reg)
);
`default_nettype wire

// *** bench/tcmc_host_model.sv ***
// Purpose: Host logic that presents characters and makes the pin clocks
// Assumes: Driven on clk falling edges; pin clocks rest low between characters
// Notes:   Data lines are scrambled once their hold time has run out
`timescale 1ns/1ps
`default_nettype none
module tcmc_host_model (
    input  wire logic       clk,
    output var logic        reference_clock,
    output var logic        chan_a_input_clock,
    output var logic [31:0] tx_char_in,
    output var logic [7:0]  tx_char_ctl
);
    // Idle levels before the first character
    initial begin
        reference_clock = 1'b0;
        chan_a_input_clock = 1'b0;
        tx_char_in = 32'h0;
        tx_char_ctl = 8'h0;
    end
    // Two clocks of setup, then three high and three low, keep clear of the two-flop sync margin
    task automatic send(input logic [31:0] chr, input logic [7:0] ctl, input logic on_a);
        @(negedge clk);
        tx_char_in = chr;
        tx_char_ctl = ctl;
        repeat (2) @(negedge clk);
        if (on_a) begin
            chan_a_input_clock = 1'b1;
        end else begin
            reference_clock = 1'b1;
        end
        repeat (3) @(negedge clk);
        reference_clock = 1'b0;
        chan_a_input_clock = 1'b0;
        repeat (3) @(negedge clk);
        tx_char_in = ~chr;
        tx_char_ctl = ~ctl;
    endtask
endmodule // tcmc_host_model
`default_nettype wire

// *** bench/tcmc_tx_char_ctrl_tb_top.sv ***
// Purpose: Self-checking bench for the transmit character and mode control block
// Assumes: The bench stalls the output and pops one word per check
// Notes:   Selects change only with the output buffer empty
`timescale 1ns/1ps
`include "tcmc_defines.vh"
`default_nettype none
module tcmc_tx_char_ctrl_tb_top;
    localparam logic [2:0]  KD = `TCMC_K_DATA;
    localparam logic [2:0]  KS = `TCMC_K_SPECIAL;
    localparam logic [2:0]  KF = `TCMC_K_FILL;
    localparam logic [31:0] CH = 32'h44332211;
    localparam logic [39:0] DD = {2'h0, CH[31:24], 2'h0, CH[23:16], 2'h0, CH[15:8], 2'h0, CH[7:0]};
    localparam logic [39:0] DB = DD | 40'hc0_2004_0000;
    logic        clk, rst, special_code_table_sel, tx_code_ready, on_a;
    logic        reference_clock, chan_a_input_clock, tx_char_ready, tx_code_valid;
    logic [3:0]  tx_op_sel, rx_bonding_sel, tx_mode_num_reg, seq_on_reg;
    logic [1:0]  tx_input_clk_sel;
    logic [31:0] tx_char_in;
    logic [7:0]  tx_char_ctl;
    logic [11:0] tx_code_kind;
    logic [39:0] tx_code_data;
    int          n_mismatch, n_compared, i;
    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    tcmc_tx_char_ctrl dut_u (
        .clk(clk), .rst(rst), .tx_op_sel(tx_op_sel), .rx_bonding_sel(rx_bonding_sel),
        .tx_input_clk_sel(tx_input_clk_sel), .special_code_table_sel(special_code_table_sel),
        .reference_clock(reference_clock), .chan_a_input_clock(chan_a_input_clock),
        .tx_char_in(tx_char_in), .tx_char_ctl(tx_char_ctl), .tx_char_ready(tx_char_ready),
        .tx_code_valid(tx_code_valid), .tx_code_ready(tx_code_ready), .tx_code_kind(tx_code_kind),
        .tx_code_data(tx_code_data), .tx_mode_num_reg(tx_mode_num_reg), .seq_on_reg(seq_on_reg)
    );
    tcmc_host_model host_u (
        .clk(clk), .reference_clock(reference_clock), .chan_a_input_clock(chan_a_input_clock),
        .tx_char_in(tx_char_in), .tx_char_ctl(tx_char_ctl)
    );
    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // New selects need two sync clocks plus the checker's settling window
    task automatic setcfg(input logic [3:0] op, input logic [3:0] bond);
        tx_op_sel = op;
        rx_bonding_sel = bond;
        repeat (12) @(negedge clk);
    endtask
    // Bounded wait for a word, compare, then pop it with a one-cycle ready
    task automatic expect_word(input logic [11:0] k, input logic [39:0] d);
        int t;
        t = 0;
        while (tx_code_valid !== 1'b1 && t < 30) begin
            @(negedge clk);
            t++;
        end
        if (t == 30) begin
            n_mismatch++;
            $display("[FAIL] no word within 30 clocks");
            tally_and_finish();
        end
        check("kind", tx_code_kind, k);
        check("payload", tx_code_data, d);
        tx_code_ready = 1'b1;
        @(negedge clk);
        tx_code_ready = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] ctl, input logic [11:0] k, input logic [39:0] d);
        host_u.send(CH, ctl, on_a);
        expect_word(k, d);
    endtask
    // Channels in m show sync positions p0 onwards, the rest show k and d
    task automatic seq_run(input logic [7:0] ctl, input logic [11:0] k, input logic [39:0] d,
                           input logic [3:0] m, input int p0, input int n);
        logic [11:0] ke;
        logic [39:0] de;
        int          p, c;
        for (p = p0; p < p0 + n; p++) begin
            ke = k;
            de = d;
            for (c = 0; c < 4; c++) begin
                if (m[c]) begin
                    ke[3*c+:3] = `TCMC_K_SYNC;
                    de[10*c+:10] = {6'h0, 4'(p)};
                end
            end
            xfer(ctl, ke, de);
        end
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        tx_op_sel = 4'h0;
        rx_bonding_sel = 4'h0;
        tx_input_clk_sel = 2'h0;
        special_code_table_sel = 1'b1;
        tx_code_ready = 1'b0;
        on_a = 1'b0;
        n_mismatch = 0;
        n_compared = 0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        check("ready", tx_char_ready, 40'h1);
        for (i = 0; i < 9; i++) begin
            setcfg({2'(i / 3), 2'(i % 3)}, 4'h0);
            check("mode", tx_mode_num_reg, 40'(i));
        end
        setcfg(4'h0, 4'h0);
        xfer(8'he4, 12'h0, DB);
        // Channel A clock selected: reference edges take nothing
        tx_input_clk_sel = 2'h2;
        repeat (4) @(negedge clk);
        host_u.send(CH, 8'he4, 1'b0);
        check("ref ignored", tx_code_valid, 40'h0);
        on_a = 1'b1;
        xfer(8'he4, 12'h0, DB);
        on_a = 1'b0;
        tx_input_clk_sel = 2'h0;
        for (i = 1; i < 3; i++) begin
            setcfg(4'(i), 4'h0);
            xfer(8'he4, {4{KF}}, 40'h0);
        end
        setcfg(4'h0, 4'h0);
        xfer(8'he4, 12'h0, DB);
        for (i = 0; i < 2; i++) begin
            setcfg(i ? 4'h9 : 4'h5, 4'h0);
            xfer(8'hb4, {KD, KS, KF, KD}, {DD[39:30], 2'h2, CH[23:16], 10'h0, DD[9:0]});
        end
        // Atomic: inputs ignored for 15 more, then 11 at the end restarts
        setcfg(4'h4, 4'h0);
        seq_run(8'he4, {KD, KD, KF, KD}, {10'h0, DD[29:20], 10'h0, DD[9:0]}, 4'h8, 0, 1);
        check("seq on", seq_on_reg, 40'h8);
        seq_run(8'h55, {4{KF}}, 40'h0, 4'h8, 1, 15);
        check("seq off", seq_on_reg, 40'h0);
        seq_run(8'hff, 12'h0, 40'h0, 4'hf, 0, 1);
        seq_run(8'h55, 12'h0, 40'h0, 4'hf, 1, 15);
        setcfg(4'h6, 4'h0);
        seq_run(8'he4, {KD, KS, KF, KD}, {10'h0, 2'h2, CH[23:16], 10'h0, DD[9:0]}, 4'h8, 0, 1);
        seq_run(8'h00, {4{KD}}, DD, 4'h8, 1, 15);
        // Interruptible: 00 continues, anything else ends the run
        setcfg(4'h8, 4'h0);
        seq_run(8'hff, 12'h0, 40'h0, 4'hf, 0, 1);
        seq_run(8'h00, 12'h0, 40'h0, 4'hf, 1, 1);
        xfer(8'h55, {4{KF}}, 40'h0);
        check("seq cut", seq_on_reg, 40'h0);
        xfer(8'h00, {4{KD}}, DD);
        setcfg(4'h6, 4'h4);
        seq_run(8'h24, {KD, KS, 6'h0}, {DD[39:30], 2'h2, CH[23:16], 20'h0}, 4'h3, 0, 1);
        seq_run(8'h00, {4{KD}}, DD, 4'h3, 1, 15);
        seq_run(8'h40, {4{KD}}, DD, 4'hc, 0, 1);
        seq_run(8'h00, {4{KD}}, DD, 4'hc, 1, 15);
        // Table select low now, so a stuck-high table bit shows
        special_code_table_sel = 1'b0;
        setcfg(4'ha, 4'h8);
        xfer(8'h60, {KD, KS, KD, KD}, {DD[39:30], 2'h0, CH[23:16], DD[19:0]});
        // Stalled drain: two words held, a third character is dropped
        setcfg(4'h0, 4'h0);
        host_u.send(CH, 8'h00, 1'b0);
        host_u.send(~CH, 8'h00, 1'b0);
        check("full", tx_char_ready, 40'h0);
        host_u.send(CH, 8'h00, 1'b0);
        expect_word(12'h0, DD);
        expect_word(12'h0, DD ^ {4{10'h0ff}});
        check("empty", tx_code_valid, 40'h0);
        tally_and_finish();
    end
endmodule // tcmc_tx_char_ctrl_tb_top
`default_nettype wire
